// >>> cpm_pkg.sv
package cpm_pkg;

  // ----------------------------------------
  // Clock and fault delay times
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_OV_NS = 1000000;
  localparam int T_UV_NS = 1000000;
  localparam int T_OCC_NS = 8000;
  localparam int T_OCD_NS = 8000;
  localparam int T_SCD_NS = 300;
  localparam int DLY_W = 24;

  // Least time, rounded up, never below one cycle
  function automatic int cyc_ceil(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_ceil

  // ----------------------------------------
  // Threshold tables, all in mV
  // ----------------------------------------
  localparam logic [12:0] OV_BASE_MV = 13'h10b3;
  localparam logic [12:0] OV_STEP_MV = 13'h0019;
  localparam logic [31:0] OCC_TAB = 32'h1c120d06;
  localparam logic [63:0] OCD_TAB = 64'h53493f352c22180e;
  localparam logic [7:0] SCD_LO_MV = 8'h49;
  localparam logic [7:0] SCD_HI_MV = 8'h94;

  typedef struct packed {
    logic scd_sel;
    logic [2:0] ocd_sel;
    logic [1:0] occ_sel;
    logic [2:0] ov_sel;
  } cfg_s;
  localparam int CFG_W = $bits(cfg_s);
  localparam cfg_s CFG_RST = '{scd_sel: 1'b0, ocd_sel: 3'h2,
                               occ_sel: 2'h2, ov_sel: 3'h7};

  function automatic logic [12:0] ov_mv(input logic [2:0] sel);
    return 13'(OV_BASE_MV + 13'(sel) * OV_STEP_MV);
  endfunction : ov_mv

  function automatic logic [7:0] occ_mv(input logic [1:0] sel);
    return OCC_TAB[{sel, 3'h0} +: 8];
  endfunction : occ_mv

  function automatic logic [7:0] ocd_mv(input logic [2:0] sel);
    return OCD_TAB[{sel, 3'h0} +: 8];
  endfunction : ocd_mv

  function automatic logic [7:0] scd_mv(input logic sel);
    return sel ? SCD_HI_MV : SCD_LO_MV;
  endfunction : scd_mv

  // ----------------------------------------
  // Register map and bus answers
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h08;
  localparam int CTRL_CHG_OFF = 0;
  localparam int CTRL_DSG_OFF = 1;
  localparam int CTRL_SHUT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Modes, comparator bundle, status
  // ----------------------------------------
  typedef enum logic [2:0] {
    MD_NORMAL, MD_OV, MD_UV, MD_OCC, MD_OCD,
    MD_SHUT_WAIT, MD_ANA_SHDN, MD_LV_CHG
  } mode_e;

  typedef struct packed {
    logic ov_above;
    logic ov_rel_below;
    logic uv_below;
    logic uv_rel_above;
    logic occ_above;
    logic ocd_above;
    logic scd_above;
    logic pack_low;
    logic chg_det;
    logic lv_chg;
  } cmp_s;

  typedef struct packed {
    logic [4:0] faults;
    logic shut_flag;
    logic reg_en;
    logic dsg_en;
    logic chg_en;
    mode_e mode;
  } status_s;

endpackage : cpm_pkg

// >>> fault_qualifier.sv
`timescale 1ns/10ps
module fault_qualifier
  import cpm_pkg::*;
#(
  parameter int DLY = 1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cond,
  output logic fault
);
  localparam logic [DLY_W-1:0] LAST = DLY_W'(DLY);
  logic [DLY_W-1:0] cnt_ff;
  logic [DLY_W-1:0] nxt_cnt;
  logic fault_ff;
  wire hit = (cnt_ff == LAST);

  // Any dropout restarts the count from zero
  assign nxt_cnt = !cond ? '0 : (hit ? cnt_ff : cnt_ff + 1'b1);
  assign fault = fault_ff;

  // Fault holds one cycle past the full delay: longer than it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff <= '0;
      fault_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      fault_ff <= cond & hit;
    end
  end
endmodule : fault_qualifier

// >>> prot_axil_regs.sv
`timescale 1ns/10ps
module prot_axil_regs
  import cpm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Block side
  output cfg_s cfg,
  output logic fw_chg_off,
  output logic fw_dsg_off,
  output logic shut_flag,
  input wire logic shut_take,
  input wire status_s status
);
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_got_ff, w_got_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  cfg_s cfg_ff;
  logic chg_off_ff, dsg_off_ff, shut_ff;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = wstrb_ff[i] ? wdata_ff[i*8 +: 8] : old[i*8 +: 8];
  endfunction : merge

  // Decode of the held write address and the live read address
  wire wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire wr_cfg = wr_fire & (awaddr_ff == REG_CFG);
  wire wr_ctrl = wr_fire & (awaddr_ff == REG_CTRL);
  wire wr_ok = (awaddr_ff == REG_CFG) | (awaddr_ff == REG_CTRL)
               | (awaddr_ff == REG_STAT);
  wire rd_fire = arvalid & arready_ff;
  wire rd_ok = (araddr == REG_CFG) | (araddr == REG_CTRL)
               | (araddr == REG_STAT);
  wire [31:0] ctrl_word = 32'({shut_ff, dsg_off_ff, chg_off_ff});
  wire [31:0] cfg_word = merge(32'(cfg_ff));
  wire [31:0] ctrl_new = merge(ctrl_word);
  wire [31:0] rd_mux = (araddr == REG_CFG) ? 32'(cfg_ff) :
                       (araddr == REG_CTRL) ? ctrl_word :
                       (araddr == REG_STAT) ? 32'(status) : '0;

  // Write handshake: address and data taken in either order
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end
    else
    begin
      if (awvalid & awready_ff)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= awaddr;
        awready_ff <= 1'b0;
      end
      if (wvalid & wready_ff)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
        wready_ff <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_ff & bready)
      begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // Registers; a new shutdown write wins over the take
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_ff <= CFG_RST;
      chg_off_ff <= 1'b0;
      dsg_off_ff <= 1'b0;
      shut_ff <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        cfg_ff <= cfg_s'(cfg_word[CFG_W-1:0]);
      if (wr_ctrl)
      begin
        chg_off_ff <= ctrl_new[CTRL_CHG_OFF];
        dsg_off_ff <= ctrl_new[CTRL_DSG_OFF];
      end
      if (wr_ctrl & wstrb_ff[0] & wdata_ff[CTRL_SHUT])
        shut_ff <= 1'b1;
      else if (shut_take)
        shut_ff <= 1'b0;
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_ff & rready)
    begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign cfg = cfg_ff;
  assign fw_chg_off = chg_off_ff;
  assign fw_dsg_off = dsg_off_ff;
  assign shut_flag = shut_ff;
endmodule : prot_axil_regs

// >>> cell_protector_mode_fsm.sv
`timescale 1ns/10ps
module cell_protector_mode_fsm
  import cpm_pkg::*;
#(
  parameter int OV_DLY_CYC = cyc_ceil(T_OV_NS),
  parameter int UV_DLY_CYC = cyc_ceil(T_UV_NS)
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Analog comparator pins
  input wire cmp_s CMP_IN,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Switch and analog controls
  output logic CHG_EN,
  output logic DSG_EN,
  output logic REG_EN,
  output logic OV_RECOV_EN,
  output logic CHG_DET_EN,
  // Thresholds to the comparators
  output logic [12:0] OV_THRESH_MV,
  output logic [7:0] OCC_THRESH_MV,
  output logic [7:0] OCD_THRESH_MV,
  output logic [7:0] SCD_THRESH_MV
);
  localparam int OCC_DLY_CYC = cyc_ceil(T_OCC_NS);
  localparam int OCD_DLY_CYC = cyc_ceil(T_OCD_NS);
  localparam int SCD_DLY_CYC = cyc_ceil(T_SCD_NS);

  cmp_s cmp_meta_ff, cmp_ff;
  cfg_s cfg;
  status_s stat;
  mode_e state_ff, nxt_state;
  logic fw_chg_off, fw_dsg_off, shut_flag;
  logic q_ov, q_uv, q_occ, q_ocd, q_scd;
  logic chg_en_ff, dsg_en_ff, reg_en_ff;
  logic ov_recov_ff, chg_det_en_ff;
  logic [12:0] ov_mv_ff;
  logic [7:0] occ_mv_ff, ocd_mv_ff, scd_mv_ff;

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  // Comparators are asynchronous to CLK; two stages each
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      cmp_meta_ff <= '0;
      cmp_ff <= '0;
    end
    else
    begin
      cmp_meta_ff <= CMP_IN;
      cmp_ff <= cmp_meta_ff;
    end
  end

  // ----------------------------------------
  // Fault qualification
  // ----------------------------------------
  // One delay counter per fault source
  fault_qualifier #(.DLY(OV_DLY_CYC)) u_ov_q (
    .clk(CLK),
    .rst(SYS_RST),
    .cond(cmp_ff.ov_above),
    .fault(q_ov)
  );
  fault_qualifier #(.DLY(UV_DLY_CYC)) u_uv_q (
    .clk(CLK),
    .rst(SYS_RST),
    .cond(cmp_ff.uv_below),
    .fault(q_uv)
  );
  fault_qualifier #(.DLY(OCC_DLY_CYC)) u_occ_q (
    .clk(CLK),
    .rst(SYS_RST),
    .cond(cmp_ff.occ_above),
    .fault(q_occ)
  );
  fault_qualifier #(.DLY(OCD_DLY_CYC)) u_ocd_q (
    .clk(CLK),
    .rst(SYS_RST),
    .cond(cmp_ff.ocd_above),
    .fault(q_ocd)
  );
  fault_qualifier #(.DLY(SCD_DLY_CYC)) u_scd_q (
    .clk(CLK),
    .rst(SYS_RST),
    .cond(cmp_ff.scd_above),
    .fault(q_scd)
  );

  // Fault summary and recovery terms
  wire any_q = q_ov | q_uv | q_occ | q_ocd | q_scd;
  wire dsg_fault = q_ocd | q_scd;
  wire pack_low = cmp_ff.pack_low;
  wire chg_det = cmp_ff.chg_det;
  wire shut_take = (state_ff == MD_NORMAL) & (nxt_state == MD_SHUT_WAIT);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  prot_axil_regs u_regs (
    .clk(CLK),
    .rst(SYS_RST),
    .awaddr(AWADDR),
    .awvalid(AWVALID),
    .awready(AWREADY),
    .wdata(WDATA),
    .wstrb(WSTRB),
    .wvalid(WVALID),
    .wready(WREADY),
    .bresp(BRESP),
    .bvalid(BVALID),
    .bready(BREADY),
    .araddr(ARADDR),
    .arvalid(ARVALID),
    .arready(ARREADY),
    .rdata(RDATA),
    .rresp(RRESP),
    .rvalid(RVALID),
    .rready(RREADY),
    .cfg(cfg),
    .fw_chg_off(fw_chg_off),
    .fw_dsg_off(fw_dsg_off),
    .shut_flag(shut_flag),
    .shut_take(shut_take),
    .status(stat)
  );

  // Status word seen by software
  assign stat.faults = {q_scd, q_ocd, q_occ, q_uv, q_ov};
  assign stat.shut_flag = shut_flag;
  assign stat.reg_en = reg_en_ff;
  assign stat.dsg_en = dsg_en_ff;
  assign stat.chg_en = chg_en_ff;
  assign stat.mode = state_ff;

  // ----------------------------------------
  // Mode controller
  // ----------------------------------------
  // Fault entry outranks a pending shutdown request
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      MD_NORMAL:
        if (dsg_fault)
          nxt_state = MD_OCD;
        else if (q_occ)
          nxt_state = MD_OCC;
        else if (q_ov)
          nxt_state = MD_OV;
        else if (q_uv)
          nxt_state = MD_UV;
        else if (shut_flag)
          nxt_state = MD_SHUT_WAIT;
      MD_OV:
        if (pack_low & cmp_ff.ov_rel_below)
          nxt_state = MD_NORMAL;
      MD_UV:
        if (chg_det & cmp_ff.uv_rel_above)
          nxt_state = MD_NORMAL;
        else if (!chg_det)
          nxt_state = MD_ANA_SHDN;
      MD_OCC:
        if (pack_low)
          nxt_state = MD_NORMAL;
      MD_OCD:
        if (!pack_low)
          nxt_state = MD_NORMAL;
      MD_SHUT_WAIT:
        if (any_q)
          nxt_state = MD_NORMAL;
        else if (pack_low)
          nxt_state = MD_ANA_SHDN;
      MD_ANA_SHDN:
        if (chg_det)
          nxt_state = cmp_ff.lv_chg ? MD_LV_CHG : MD_NORMAL;
      MD_LV_CHG:
        if (q_uv)
          nxt_state = MD_UV;
        else if (!cmp_ff.lv_chg)
          nxt_state = MD_NORMAL;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      state_ff <= MD_NORMAL;
    else
      state_ff <= nxt_state;
  end

  // Which switches each mode lets through
  wire chg_allow = (state_ff == MD_NORMAL) | (state_ff == MD_UV)
                   | (state_ff == MD_OCD) | (state_ff == MD_LV_CHG);
  wire dsg_allow = (state_ff == MD_NORMAL) | (state_ff == MD_OV)
                   | (state_ff == MD_OCC);

  // ----------------------------------------
  // Output drivers
  // ----------------------------------------
  // Firmware can only take a switch away, never grant one
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      chg_en_ff <= 1'b0;
      dsg_en_ff <= 1'b0;
      reg_en_ff <= 1'b1;
      ov_recov_ff <= 1'b0;
      chg_det_en_ff <= 1'b0;
    end
    else
    begin
      chg_en_ff <= chg_allow & ~fw_chg_off;
      dsg_en_ff <= dsg_allow & ~fw_dsg_off;
      reg_en_ff <= (state_ff != MD_ANA_SHDN);
      ov_recov_ff <= (state_ff == MD_OV);
      chg_det_en_ff <= (state_ff == MD_UV);
    end
  end

  // Thresholds follow the config one cycle later
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ov_mv_ff <= ov_mv(CFG_RST.ov_sel);
      occ_mv_ff <= occ_mv(CFG_RST.occ_sel);
      ocd_mv_ff <= ocd_mv(CFG_RST.ocd_sel);
      scd_mv_ff <= scd_mv(CFG_RST.scd_sel);
    end
    else
    begin
      ov_mv_ff <= ov_mv(cfg.ov_sel);
      occ_mv_ff <= occ_mv(cfg.occ_sel);
      ocd_mv_ff <= ocd_mv(cfg.ocd_sel);
      scd_mv_ff <= scd_mv(cfg.scd_sel);
    end
  end

  assign CHG_EN = chg_en_ff;
  assign DSG_EN = dsg_en_ff;
  assign REG_EN = reg_en_ff;
  assign OV_RECOV_EN = ov_recov_ff;
  assign CHG_DET_EN = chg_det_en_ff;
  assign OV_THRESH_MV = ov_mv_ff;
  assign OCC_THRESH_MV = occ_mv_ff;
  assign OCD_THRESH_MV = ocd_mv_ff;
  assign SCD_THRESH_MV = scd_mv_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  AST_OV_DECODE: assert property (
    ##1 OV_THRESH_MV == 13'(OV_BASE_MV + OV_STEP_MV * $past(cfg.ov_sel)))
    else $error("Overvoltage threshold decode wrong");
  AST_OCC_DECODE: assert property (
    (cfg.occ_sel == CFG_RST.occ_sel) |=> OCC_THRESH_MV == OCC_TAB[23:16])
    else $error("Charge overcurrent default decode wrong");
  AST_OCD_DECODE: assert property (
    (cfg.ocd_sel == CFG_RST.ocd_sel) |=> OCD_THRESH_MV == OCD_TAB[23:16])
    else $error("Discharge overcurrent default decode wrong");
  AST_SCD_DECODE: assert property (
    cfg.scd_sel |=> SCD_THRESH_MV == SCD_HI_MV)
    else $error("Short-circuit decode wrong");
  AST_NORMAL_ON: assert property (
    (state_ff == MD_NORMAL && !fw_chg_off && !fw_dsg_off)
      |=> CHG_EN && DSG_EN)
    else $error("Switches not both on in normal mode");
  AST_FW_OFF: assert property (
    fw_chg_off || fw_dsg_off |=> !(CHG_EN && $past(fw_chg_off))
      && !(DSG_EN && $past(fw_dsg_off)))
    else $error("Firmware override did not open switch");
  AST_FAULT_WINS: assert property (
    (state_ff inside {MD_OV, MD_OCC}) |=> !CHG_EN)
    else $error("Charge switch on during charge fault");
  AST_SHUT_ENTRY: assert property (
    (state_ff == MD_NORMAL && shut_flag && !any_q)
      |=> state_ff == MD_SHUT_WAIT ##1 !CHG_EN && !DSG_EN)
    else $error("Shutdown request not taken");
  AST_SHUT_HOLD: assert property (
    (state_ff == MD_SHUT_WAIT && !any_q && pack_low)
      |=> state_ff == MD_ANA_SHDN ##1 !REG_EN)
    else $error("No power down on charger removal");
  AST_OV_ENTRY: assert property (
    (state_ff == MD_NORMAL && q_ov && !dsg_fault && !q_occ)
      |=> state_ff == MD_OV ##1 OV_RECOV_EN)
    else $error("Overvoltage fault not entered");
  AST_OV_STAY: assert property (
    (state_ff == MD_OV && !(pack_low && cmp_ff.ov_rel_below))
      |=> state_ff == MD_OV)
    else $error("Overvoltage released early");
  AST_UV_PATH: assert property (
    (state_ff == MD_UV && !chg_det) |=> state_ff == MD_ANA_SHDN)
    else $error("No analog shutdown without charger");
  AST_UV_CLEAR: assert property (
    (state_ff == MD_UV && chg_det && cmp_ff.uv_rel_above)
      |=> state_ff == MD_NORMAL)
    else $error("Undervoltage not cleared");
  AST_OCD_CLEAR: assert property (
    (state_ff == MD_OCD && pack_low) |=> state_ff == MD_OCD)
    else $error("Discharge fault released with pack low");
  AST_SHUT_ABORT: assert property (
    (state_ff == MD_SHUT_WAIT && any_q) |=> state_ff == MD_NORMAL)
    else $error("Shutdown not abandoned on fault");
  AST_QUAL_HELD: assert property (
    $rose(q_ov) |-> $past(cmp_ff.ov_above, 2) && $past(cmp_ff.ov_above))
    else $error("Overvoltage fault without held condition");

  COV_SHUTDOWN: cover property (
    state_ff == MD_SHUT_WAIT ##[1:1000] state_ff == MD_ANA_SHDN);
  COV_OV_ROUND: cover property (
    state_ff == MD_OV ##[1:1000] state_ff == MD_NORMAL);
  COV_UV_SHDN: cover property (
    state_ff == MD_UV ##1 state_ff == MD_ANA_SHDN);
endmodule : cell_protector_mode_fsm

// >>> analog_front.sv
`timescale 1ns/10ps
// Cell, sense and pack front end as the protector sees it
module analog_front
  import cpm_pkg::*;
#(
  parameter int OV_REL_MV = 4150,
  parameter int UV_MV = 2500,
  parameter int UV_REL_MV = 2900
)
(
  // Levels in mV and charger flags
  input wire logic [12:0] cell_mv,
  input wire logic [7:0] chg_mv,
  input wire logic [7:0] dsg_mv,
  input wire logic [9:0] drop_mv,
  input wire logic chg_det,
  input wire logic lv_chg,
  // Thresholds from the protector
  input wire logic [12:0] ov_thr,
  input wire logic [7:0] occ_thr,
  input wire logic [7:0] ocd_thr,
  input wire logic [7:0] scd_thr,
  // Comparator outputs
  output cmp_s cmp
);
  // ------------------
  // Comparators
  // ------------------
  // Ideal, no hysteresis: tests keep their levels well clear of each edge
  assign cmp.ov_above = cell_mv > ov_thr;
  assign cmp.ov_rel_below = cell_mv < 13'(OV_REL_MV);
  assign cmp.uv_below = cell_mv < 13'(UV_MV);
  assign cmp.uv_rel_above = cell_mv > 13'(UV_REL_MV);
  assign cmp.occ_above = chg_mv > occ_thr;
  assign cmp.ocd_above = dsg_mv > ocd_thr;
  assign cmp.scd_above = dsg_mv > scd_thr;
  assign cmp.pack_low = drop_mv > 10'h12c;
  assign cmp.chg_det = chg_det;
  // Deep-discharge charging flag comes straight from the bench
  assign cmp.lv_chg = lv_chg;
endmodule : analog_front

// >>> cell_protector_mode_fsm_bench.sv
`timescale 1ns/10ps
module cell_protector_mode_fsm_bench
  import cpm_pkg::*;
();
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  cmp_s CMP_IN;
  logic [7:0] AWADDR = 8'h0, ARADDR = 8'h0;
  logic [31:0] WDATA = 32'h0, RDATA, rd;
  logic [3:0] WSTRB = 4'h0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic ARVALID = 1'b0, RREADY = 1'b0, chg_det = 1'b0, lv_chg = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic CHG_EN, DSG_EN, REG_EN, OV_RECOV_EN, CHG_DET_EN;
  logic [1:0] BRESP, RRESP;
  logic [12:0] OV_THRESH_MV, cell_mv = 13'h0e74;
  logic [7:0] OCC_THRESH_MV, OCD_THRESH_MV, SCD_THRESH_MV;
  logic [7:0] chg_mv = 8'h0, dsg_mv = 8'h0;
  logic [9:0] drop_mv = 10'h0;
  int fails = 0, n_checks = 0, cyc = 0;
  int occ_t[4] = '{6, 13, 18, 28};
  int ocd_t[8] = '{14, 24, 34, 44, 53, 63, 73, 83};

  // Short voltage delays keep the run brief
  cell_protector_mode_fsm #(.OV_DLY_CYC(4), .UV_DLY_CYC(4)) dut (
    .CLK, .SYS_RST, .CMP_IN, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
    .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID,
    .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .CHG_EN, .DSG_EN, .REG_EN,
    .OV_RECOV_EN, .CHG_DET_EN, .OV_THRESH_MV, .OCC_THRESH_MV,
    .OCD_THRESH_MV, .SCD_THRESH_MV);
  analog_front far (.cell_mv, .chg_mv, .dsg_mv, .drop_mv, .chg_det,
    .lv_chg, .ov_thr(OV_THRESH_MV), .occ_thr(OCC_THRESH_MV),
    .ocd_thr(OCD_THRESH_MV), .scd_thr(SCD_THRESH_MV), .cmp(CMP_IN));

  // 40 MHz clock
  always #12.5 CLK = ~CLK;

  // Hang guard, well above the expected run length
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      print_verdict();
    end
  end

  // ------------------
  // Tasks
  // ------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge CLK);
  endtask : wt

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= 4'hf;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    forever
    begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID) break;
    end
    chk("bresp", BRESP, RESP_OKAY);
    BREADY <= 1'b0;
    @(posedge CLK);
  endtask : wr

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    forever
    begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID) break;
    end
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
    @(posedge CLK);
  endtask : rd_reg

  // ------------------
  // Tests
  // ------------------
  initial
  begin
    logic [1:0] r;
    wt(8);
    SYS_RST <= 1'b0;
    wt(3);
    chk("ov", OV_THRESH_MV, 4450);
    chk("occ", OCC_THRESH_MV, 18);
    chk("ocd", OCD_THRESH_MV, 34);
    chk("scd", SCD_THRESH_MV, 73);
    chk("sw", {CHG_EN, DSG_EN}, 2'h3);
    rd_reg(REG_CFG, rd, r);
    chk("cfg", rd, 32'h57);
    rd_reg(8'h40, rd, r);
    chk("unmapped", r, RESP_SLVERR);
    // Every select code of each field
    for (int i = 0; i < 8; i++)
    begin
      wr(REG_CFG, {23'h0, i[0], i[2:0], i[1:0], i[2:0]});
      wt(2);
      chk("ov", OV_THRESH_MV, 4275 + 25 * i);
      chk("occ", OCC_THRESH_MV, occ_t[i[1:0]]);
      chk("ocd", OCD_THRESH_MV, ocd_t[i]);
      chk("scd", SCD_THRESH_MV, i[0] ? 148 : 73);
    end
    wr(REG_CFG, 32'(CFG_RST));
    // Firmware forces each switch off, then both, then none
    for (int i = 1; i < 5; i++)
    begin
      wr(REG_CTRL, 32'(i[1:0]));
      wt(3);
      chk("fw", {CHG_EN, DSG_EN}, {~i[0], ~i[1]});
    end
    // Short overvoltage burst must not trip
    cell_mv <= 13'h1194;
    wt(3);
    cell_mv <= 13'h0e74;
    wt(14);
    chk("burst", CHG_EN, 1'b1);
    cell_mv <= 13'h1194;
    wt(14);
    chk("ov_on", {CHG_EN, DSG_EN, OV_RECOV_EN}, 3'h3);
    wr(REG_CTRL, 32'h0);
    cell_mv <= 13'h0e74;
    wt(14);
    chk("ov_hold", CHG_EN, 1'b0);
    drop_mv <= 10'h190;
    wt(14);
    chk("ov_clr", {CHG_EN, OV_RECOV_EN}, 2'h2);
    drop_mv <= 10'h0;
    // Charge overcurrent, recovered only by charger removal
    chg_mv <= 8'h14;
    wt(340);
    chg_mv <= 8'h0;
    wt(14);
    chk("occ_hold", CHG_EN, 1'b0);
    drop_mv <= 10'h190;
    wt(14);
    chk("occ_clr", CHG_EN, 1'b1);
    // Short circuit with the pack pulled down
    dsg_mv <= 8'h64;
    wt(30);
    dsg_mv <= 8'h0;
    wt(14);
    chk("scd_hold", {CHG_EN, DSG_EN}, 2'h2);
    drop_mv <= 10'h0;
    wt(14);
    chk("scd_clr", DSG_EN, 1'b1);
    // Undervoltage with a charger present, then without
    chg_det <= 1'b1;
    cell_mv <= 13'h07d0;
    wt(14);
    chk("uv", {DSG_EN, CHG_DET_EN, REG_EN}, 3'h3);
    cell_mv <= 13'h0e74;
    wt(14);
    chk("uv_clr", {DSG_EN, CHG_DET_EN}, 2'h2);
    chg_det <= 1'b0;
    cell_mv <= 13'h07d0;
    wt(14);
    chk("ana", REG_EN, 1'b0);
    // Deep-discharge charger: low-voltage charging falls back into UV
    chg_det <= 1'b1;
    lv_chg <= 1'b1;
    wt(14);
    chk("lv_uv", {REG_EN, DSG_EN, CHG_DET_EN}, 3'h5);
    cell_mv <= 13'h0e74;
    lv_chg <= 1'b0;
    wt(14);
    chg_det <= 1'b0;
    chk("wake", {REG_EN, DSG_EN}, 2'h3);
    // Shutdown request waits for charger removal
    wr(REG_CTRL, 32'h4);
    wt(6);
    rd_reg(REG_STAT, rd, r);
    chk("shut", rd[6:0], 7'h25);
    // A fault during the wait abandons the shutdown
    dsg_mv <= 8'h64;
    wt(30);
    dsg_mv <= 8'h0;
    wt(14);
    chk("abort", {REG_EN, DSG_EN}, 2'h3);
    wr(REG_CTRL, 32'h4);
    wt(6);
    drop_mv <= 10'h190;
    wt(14);
    chk("shut_off", REG_EN, 1'b0);
    print_verdict();
  end
endmodule : cell_protector_mode_fsm_bench
